// [bfs_pkg.sv]
// Package: register indices, field positions, reset values and the threshold scale
package bfs_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int          ADDR_W           = 10;
   localparam logic [1:0]  RESP_OKAY        = 2'b00;
   localparam logic [1:0]  RESP_DECERR      = 2'b11;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [7:0]  IDX_CH1_LATCH    = 8'h2e;
   localparam logic [7:0]  IDX_CH2_LATCH    = 8'h2f;
   localparam logic [7:0]  IDX_MASK_THREE   = 8'h34;
   localparam logic [7:0]  IDX_NEG_OV_LATCH = 8'h36;
   localparam logic [7:0]  IDX_BIAS_LATCH   = 8'h37;
   localparam logic [7:0]  IDX_HIGH_LIMIT   = 8'h38;
   localparam logic [7:0]  IDX_LOW_LIMIT    = 8'h39;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int          POS_NEG_OV_CH1   = 7;
   localparam int          POS_NEG_OV_CH2   = 6;
   localparam int          POS_BIAS_HIGH    = 7;
   localparam int          POS_BIAS_LOW     = 6;
   localparam int          POS_BIAS_OV      = 5;
   localparam int          POS_MASK_LSB     = 3;
   localparam logic [7:0]  HIGH_LIMIT_RST   = 8'hba;
   localparam logic [7:0]  LOW_LIMIT_RST    = 8'h4b;
   localparam logic [4:0]  MASK_THREE_RST   = 5'h00;

   // ---------------------------------------------------------------
   // Threshold scale: code 57 is 0 mA, 540 uA per code above it
   // ---------------------------------------------------------------
   localparam logic [16:0] ZERO_CODE        = 17'h00039;
   localparam logic [16:0] UA_PER_CODE      = 17'h0021c;

   // Threshold code to microamps; codes under zero point give 0
   function automatic logic [16:0] bfs_code_to_ua(input logic [7:0] code);
      logic [16:0] steps;
      steps = 17'(code) - ZERO_CODE;
      if (17'(code) < ZERO_CODE) begin
         return 17'h00000;
      end
      return 17'(steps * UA_PER_CODE);
   endfunction

endpackage

// [bfs_bias_monitor.sv]
// Bias load-current and over-voltage fault detector
module bfs_bias_monitor
   import bfs_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic [16:0] bias_load_ua,
   input  wire logic        bias_ov_raw,
   input  wire logic [7:0]  high_load_current_threshold,
   input  wire logic [7:0]  low_load_current_threshold,
   output logic             high_det,
   output logic             low_det,
   output logic             ov_det
);

   typedef struct packed {
      logic high;
      logic low;
      logic ov;
   } bfs_mon_t;

   bfs_mon_t    mon_reg;
   bfs_mon_t    mon_next;
   logic [16:0] high_ua;
   logic [16:0] low_ua;

   // ---------------------------------------------------------------
   // Compare measured load against both limits
   // ---------------------------------------------------------------
   always_comb begin
      high_ua       = bfs_code_to_ua(high_load_current_threshold);
      low_ua        = bfs_code_to_ua(low_load_current_threshold);
      mon_next      = mon_reg;
      mon_next.high = bias_load_ua > high_ua;
      mon_next.low  = bias_load_ua < low_ua;
      mon_next.ov   = bias_ov_raw;
   end

   // Register detections so the latch sees clean one-clock levels
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         mon_reg <= '0;
      end else begin
         mon_reg <= mon_next;
      end
   end

   assign high_det = mon_reg.high;
   assign low_det  = mon_reg.low;
   assign ov_det   = mon_reg.ov;

   // Detection follows comparison with one clock of delay
   high_cmp_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (bias_load_ua > bfs_code_to_ua(high_load_current_threshold)) |=> high_det)
      else $error("high current not detected");

endmodule // bfs_bias_monitor

// [bfs_fault_regs.sv]
// Bias fault, negative-input over-voltage latches and threshold registers
// Summary of operation
// - Bit 7 latches channel one negative over-voltage
// - Reading channel one latch clears that flag
// - Bit 6 latches channel two negative over-voltage
// - Reading channel two latch clears that flag
// - Bits 5..0 of negative latch read zero
// - Bias latch bit 7 flags high current
// - Bias latch bit 6 flags low current
// - Bias latch bit 5 flags bias over-voltage
// - Bias latch bits 4..0 read zero
// - High limit register, resets to 186
// - High code 57 means 0 mA, 0.54 mA steps
// - Low limit register, resets to 75
// - Low code 57 means 0 mA, 0.54 mA steps
// - Mask bits 5,4,3 suppress bias fault alerts
module bfs_fault_regs
   import bfs_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Fault detection inputs
   input  wire logic              channel_one_negative_input_ov,
   input  wire logic              channel_two_negative_input_ov,
   input  wire logic [16:0]       microphone_bias_output_load_ua,
   input  wire logic              microphone_bias_output_ov,
   // Fault summary after masking
   output logic                   bias_fault_alert
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      WS_IDLE = 2'b01,
      WS_RESP = 2'b10
   } bfs_wstate_t;

   typedef struct packed {
      bfs_wstate_t wstate;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [7:0]  rd_idx;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  wr_idx;
      logic [7:0]  wr_data;
      logic        wr_lane0;
      logic [1:0]  neg_ov;      // [1] channel one, [0] channel two
      logic [2:0]  bias_flt;    // [2] high, [1] low, [0] over-voltage
      logic [7:0]  high_limit;
      logic [7:0]  low_limit;
      logic [4:0]  mask_three;  // mask bits 7..3
      logic        alert;
   } bfs_state_t;

   bfs_state_t st_reg;
   bfs_state_t st_next;
   logic       bias_high_det;
   logic       bias_low_det;
   logic       bias_ov_det;
   logic       ar_hs;
   logic [7:0] ar_idx;
   logic [1:0] neg_clr;
   logic       bias_clr;

   // Map an index onto a register: is it one we answer?
   function automatic logic bfs_mapped(input logic [7:0] idx);
      return (idx == IDX_CH1_LATCH) || (idx == IDX_CH2_LATCH) ||
             (idx == IDX_MASK_THREE) || (idx == IDX_NEG_OV_LATCH) ||
             (idx == IDX_BIAS_LATCH) || (idx == IDX_HIGH_LIMIT) ||
             (idx == IDX_LOW_LIMIT);
   endfunction

   // ---------------------------------------------------------------
   // Bias current and over-voltage detector
   // ---------------------------------------------------------------
   bfs_bias_monitor u_monitor (
      .clk_sys                     (clk_sys),
      .nrst                        (nrst),
      .bias_load_ua                (microphone_bias_output_load_ua),
      .bias_ov_raw                 (microphone_bias_output_ov),
      .high_load_current_threshold (st_reg.high_limit),
      .low_load_current_threshold  (st_reg.low_limit),
      .high_det                    (bias_high_det),
      .low_det                     (bias_low_det),
      .ov_det                      (bias_ov_det)
   );

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      ar_hs   = s_axi_arvalid && st_reg.arready;
      ar_idx  = s_axi_araddr[ADDR_W-1:2];

      // Read channel: one read under way at a time
      if (ar_hs) begin
         st_next.arready = 1'b0;
         st_next.rvalid  = 1'b1;
         st_next.rd_idx  = ar_idx;
         st_next.rresp   = bfs_mapped(ar_idx) ? RESP_OKAY : RESP_DECERR;
         st_next.rdata   = 32'h00000000;
         unique case (ar_idx)
            IDX_MASK_THREE:   st_next.rdata[7:3] = st_reg.mask_three;
            IDX_NEG_OV_LATCH: st_next.rdata[7:6] = st_reg.neg_ov;
            IDX_BIAS_LATCH:   st_next.rdata[7:5] = st_reg.bias_flt;
            IDX_HIGH_LIMIT:   st_next.rdata[7:0] = st_reg.high_limit;
            IDX_LOW_LIMIT:    st_next.rdata[7:0] = st_reg.low_limit;
            default:          st_next.rdata      = 32'h00000000;
         endcase
      end else if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid  = 1'b0;
         st_next.arready = 1'b1;
      end else if (!st_reg.rvalid) begin
         st_next.arready = 1'b1;
      end

      // Clear-on-read strobes, taken when the address is accepted
      neg_clr[1] = ar_hs && (ar_idx == IDX_CH1_LATCH);
      neg_clr[0] = ar_hs && (ar_idx == IDX_CH2_LATCH);
      bias_clr   = ar_hs && (ar_idx == IDX_BIAS_LATCH);

      // Latches: a new event in the clearing cycle wins
      st_next.neg_ov[1] = (st_reg.neg_ov[1] && !neg_clr[1]) ||
                          channel_one_negative_input_ov;
      st_next.neg_ov[0] = (st_reg.neg_ov[0] && !neg_clr[0]) ||
                          channel_two_negative_input_ov;
      st_next.bias_flt  = (st_reg.bias_flt & {3{!bias_clr}}) |
                          {bias_high_det, bias_low_det, bias_ov_det};

      // Write channel: address and data taken in either order
      unique case (st_reg.wstate)
         WS_IDLE: begin
            if (s_axi_awvalid && st_reg.awready) begin
               st_next.aw_got = 1'b1;
               st_next.wr_idx = s_axi_awaddr[ADDR_W-1:2];
            end
            if (s_axi_wvalid && st_reg.wready) begin
               st_next.w_got    = 1'b1;
               st_next.wr_data  = s_axi_wdata[7:0];
               st_next.wr_lane0 = s_axi_wstrb[0];
            end
            if (st_reg.aw_got && st_reg.w_got) begin
               st_next.aw_got = 1'b0;
               st_next.w_got  = 1'b0;
               st_next.bvalid = 1'b1;
               st_next.wstate = WS_RESP;
               st_next.bresp  = bfs_mapped(st_reg.wr_idx) ? RESP_OKAY : RESP_DECERR;
               // Read-only and reserved bits ignore the write
               if (st_reg.wr_lane0) begin
                  unique case (st_reg.wr_idx)
                     IDX_HIGH_LIMIT: st_next.high_limit = st_reg.wr_data;
                     IDX_LOW_LIMIT:  st_next.low_limit  = st_reg.wr_data;
                     IDX_MASK_THREE: st_next.mask_three = st_reg.wr_data[7:3];
                     default:        st_next.high_limit = st_reg.high_limit;
                  endcase
               end
            end
            st_next.awready = !st_next.aw_got && (st_next.wstate == WS_IDLE);
            st_next.wready  = !st_next.w_got && (st_next.wstate == WS_IDLE);
         end
         WS_RESP: begin
            st_next.awready = 1'b0;
            st_next.wready  = 1'b0;
            if (s_axi_bready) begin
               st_next.bvalid  = 1'b0;
               st_next.wstate  = WS_IDLE;
               st_next.awready = 1'b1;
               st_next.wready  = 1'b1;
            end
         end
         default: begin
            st_next.wstate = WS_IDLE;
         end
      endcase

      // Alert: unmasked bias faults, plus negative over-voltage unless mask bit 6 is set
      st_next.alert = |(st_reg.bias_flt & ~st_reg.mask_three[2:0]) ||
                      (|st_reg.neg_ov && !st_reg.mask_three[POS_MASK_LSB]);
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_reg            <= '0;
         st_reg.wstate     <= WS_IDLE;
         st_reg.bresp      <= RESP_OKAY;
         st_reg.rresp      <= RESP_OKAY;
         st_reg.high_limit <= HIGH_LIMIT_RST;
         st_reg.low_limit  <= LOW_LIMIT_RST;
         st_reg.mask_three <= MASK_THREE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all straight from the state register
   // ---------------------------------------------------------------
   assign s_axi_awready    = st_reg.awready;
   assign s_axi_wready     = st_reg.wready;
   assign s_axi_bvalid     = st_reg.bvalid;
   assign s_axi_bresp      = st_reg.bresp;
   assign s_axi_arready    = st_reg.arready;
   assign s_axi_rvalid     = st_reg.rvalid;
   assign s_axi_rresp      = st_reg.rresp;
   assign s_axi_rdata      = st_reg.rdata;
   assign bias_fault_alert = st_reg.alert;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   neg_one_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      channel_one_negative_input_ov |=> st_reg.neg_ov[1])
      else $error("channel one negative over-voltage not latched");

   neg_one_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (ar_hs && ar_idx == IDX_CH1_LATCH && !channel_one_negative_input_ov)
      |=> !st_reg.neg_ov[1])
      else $error("channel one flag not cleared by read");

   neg_two_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      channel_two_negative_input_ov |=> st_reg.neg_ov[0])
      else $error("channel two negative over-voltage not latched");

   neg_two_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (ar_hs && ar_idx == IDX_CH2_LATCH && !channel_two_negative_input_ov)
      |=> !st_reg.neg_ov[0])
      else $error("channel two flag not cleared by read");

   rsvd_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_axi_rvalid && (st_reg.rd_idx == IDX_NEG_OV_LATCH || st_reg.rd_idx == IDX_BIAS_LATCH))
      |-> (s_axi_rdata[31:8] == 24'h000000 && s_axi_rdata[4:0] == 5'h00 &&
           (st_reg.rd_idx != IDX_NEG_OV_LATCH || s_axi_rdata[5] == 1'b0)))
      else $error("reserved bits of latch read nonzero");

   bias_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (bias_high_det && !bias_clr) ##1 !bias_clr |=> st_reg.bias_flt[2])
      else $error("high current fault not held");

   bias_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (bias_clr && !bias_high_det && !bias_low_det && !bias_ov_det)
      |=> st_reg.bias_flt == 3'b000)
      else $error("bias latch not cleared by read");

   limit_reset_a: assert property (@(posedge clk_sys)
      !nrst |=> (st_reg.high_limit == HIGH_LIMIT_RST && st_reg.low_limit == LOW_LIMIT_RST))
      else $error("threshold reset value wrong");

   alert_mask_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_reg.mask_three[2:0] == 3'b111 && st_reg.neg_ov == 2'b00) |=> !bias_fault_alert)
      else $error("masked bias fault raised alert");

endmodule // bfs_fault_regs

// [tb_top.sv]
// Self-checking testbench for the bias fault latch and threshold registers
`define CHK(nm, ex, got) \
   begin \
      tests_run++; \
      if ((got) !== (ex)) begin \
         n_mismatch++; \
         $display("Error %s expected %0h seen %0h", nm, ex, got); \
      end \
   end

module tb_top
   import bfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ---------------------------------------------------------------
   // Signals and table of ordinary register cases
   // ---------------------------------------------------------------
   typedef struct {
      logic [7:0] idx;
      logic [3:0] strb;
      logic [7:0] wd;
      logic [1:0] bresp;
      logic [7:0] rd;
      logic [1:0] rresp;
   } bfs_row_t;

   logic              clk_sys;
   logic              nrst;
   logic [ADDR_W-1:0] s_axi_awaddr;
   logic              s_axi_awvalid;
   logic              s_axi_awready;
   logic [31:0]       s_axi_wdata;
   logic [3:0]        s_axi_wstrb;
   logic              s_axi_wvalid;
   logic              s_axi_wready;
   logic [1:0]        s_axi_bresp;
   logic              s_axi_bvalid;
   logic              s_axi_bready;
   logic [ADDR_W-1:0] s_axi_araddr;
   logic              s_axi_arvalid;
   logic              s_axi_arready;
   logic [31:0]       s_axi_rdata;
   logic [1:0]        s_axi_rresp;
   logic              s_axi_rvalid;
   logic              s_axi_rready;
   logic              ch1_ov;
   logic              ch2_ov;
   logic [16:0]       load_ua;
   logic              bias_ov;
   logic              bias_fault_alert;
   logic [31:0]       rdat;
   logic [1:0]        rsp;
   int                n_mismatch;
   int                tests_run;

   // Reserved, read-only and unmapped places sit among the plain cases
   // High code 57 and low code 242 put the 20 mA load out of range, so the bias row sees both
   bfs_row_t rows [11] = '{
      '{IDX_HIGH_LIMIT, 4'hf, 8'h39, RESP_OKAY, 8'h39, RESP_OKAY},
      '{IDX_HIGH_LIMIT, 4'he, 8'h11, RESP_OKAY, 8'h39, RESP_OKAY},
      '{IDX_HIGH_LIMIT, 4'hf, 8'hf2, RESP_OKAY, 8'hf2, RESP_OKAY},
      '{IDX_LOW_LIMIT, 4'hf, 8'hf2, RESP_OKAY, 8'hf2, RESP_OKAY},
      '{IDX_LOW_LIMIT, 4'hf, 8'h3a, RESP_OKAY, 8'h3a, RESP_OKAY},
      '{IDX_MASK_THREE, 4'hf, 8'hff, RESP_OKAY, 8'hf8, RESP_OKAY},
      '{IDX_NEG_OV_LATCH, 4'hf, 8'hff, RESP_OKAY, 8'h00, RESP_OKAY},
      '{IDX_BIAS_LATCH, 4'hf, 8'hff, RESP_OKAY, 8'hc0, RESP_OKAY},
      '{IDX_CH1_LATCH, 4'hf, 8'ha5, RESP_OKAY, 8'h00, RESP_OKAY},
      '{8'h3f, 4'hf, 8'h5a, RESP_DECERR, 8'h00, RESP_DECERR},
      '{IDX_MASK_THREE, 4'hf, 8'h00, RESP_OKAY, 8'h00, RESP_OKAY}
   };

   bfs_fault_regs dut_u (
      .clk_sys                        (clk_sys),
      .nrst                           (nrst),
      .s_axi_awaddr                   (s_axi_awaddr),
      .s_axi_awvalid                  (s_axi_awvalid),
      .s_axi_awready                  (s_axi_awready),
      .s_axi_wdata                    (s_axi_wdata),
      .s_axi_wstrb                    (s_axi_wstrb),
      .s_axi_wvalid                   (s_axi_wvalid),
      .s_axi_wready                   (s_axi_wready),
      .s_axi_bresp                    (s_axi_bresp),
      .s_axi_bvalid                   (s_axi_bvalid),
      .s_axi_bready                   (s_axi_bready),
      .s_axi_araddr                   (s_axi_araddr),
      .s_axi_arvalid                  (s_axi_arvalid),
      .s_axi_arready                  (s_axi_arready),
      .s_axi_rdata                    (s_axi_rdata),
      .s_axi_rresp                    (s_axi_rresp),
      .s_axi_rvalid                   (s_axi_rvalid),
      .s_axi_rready                   (s_axi_rready),
      .channel_one_negative_input_ov  (ch1_ov),
      .channel_two_negative_input_ov  (ch2_ov),
      .microphone_bias_output_load_ua (load_ua),
      .microphone_bias_output_ov      (bias_ov),
      .bias_fault_alert               (bias_fault_alert)
   );

   // 10 MHz system clock
   always #50 clk_sys = ~clk_sys;

   // ---------------------------------------------------------------
   // Bus and helper tasks
   // ---------------------------------------------------------------
   // Ready is sampled at the falling edge; it is registered, so it holds to the next rise
   task automatic axi_wr(input logic [7:0] idx, input logic [3:0] strb, input logic [7:0] d,
                         output logic [1:0] resp);
      logic aw_go;
      logic w_go;
      @(posedge clk_sys);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_wstrb   <= strb;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      // No cycle limit here: only the watchdog ends a wait
      do begin
         @(negedge clk_sys);
         aw_go = s_axi_awvalid & s_axi_awready;
         w_go  = s_axi_wvalid & s_axi_wready;
         @(posedge clk_sys);
         if (aw_go) s_axi_awvalid <= 1'b0;
         if (w_go) s_axi_wvalid <= 1'b0;
      end while (!((aw_go || !s_axi_awvalid) && (w_go || !s_axi_wvalid)));
      do begin
         @(negedge clk_sys);
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      @(posedge clk_sys);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] idx, output logic [31:0] data,
                         output logic [1:0] resp);
      @(posedge clk_sys);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(negedge clk_sys);
      end while (s_axi_arready !== 1'b1);
      @(posedge clk_sys);
      s_axi_arvalid <= 1'b0;
      do begin
         @(negedge clk_sys);
      end while (s_axi_rvalid !== 1'b1);
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk_sys);
      s_axi_rready <= 1'b0;
   endtask

   task automatic chk_rd(input string nm, input logic [7:0] idx, input logic [7:0] ex);
      axi_rd(idx, rdat, rsp);
      `CHK(nm, {24'h000000, ex}, rdat)
      `CHK(nm, RESP_OKAY, rsp)
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      axi_wr(idx, 4'hf, d, rsp);
   endtask

   // Lets the monitor and latch stages settle, then leaves us off the rising edge
   task automatic settle();
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task automatic do_reset();
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (2) @(posedge clk_sys);
   endtask

   // Threshold code to microamps, worked out independently of the design
   function automatic logic [16:0] th_ua(input int code);
      return 17'((code - 57) * 540);
   endfunction

   task automatic summarize();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog: the whole run needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      summarize();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      nrst = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      {ch1_ov, ch2_ov, bias_ov} = 3'b000;
      load_ua = 17'd20000; // Inside both reset limits, so no fault at start
      n_mismatch = 0;
      tests_run = 0;
      do_reset();
      chk_rd("high_rst", IDX_HIGH_LIMIT, 8'hba);
      chk_rd("low_rst", IDX_LOW_LIMIT, 8'h4b);
      chk_rd("bias_rst", IDX_BIAS_LATCH, 8'h00);
      chk_rd("neg_rst", IDX_NEG_OV_LATCH, 8'h00);
      foreach (rows[i]) begin
         axi_wr(rows[i].idx, rows[i].strb, rows[i].wd, rsp);
         `CHK("row_bresp", rows[i].bresp, rsp)
         axi_rd(rows[i].idx, rdat, rsp);
         `CHK("row_rdata", {24'h000000, rows[i].rd}, rdat)
         `CHK("row_rresp", rows[i].rresp, rsp)
      end
      // Both negative-input flags, then cleared one at a time
      @(posedge clk_sys);
      ch1_ov <= 1'b1;
      @(posedge clk_sys);
      ch1_ov <= 1'b0;
      settle();
      chk_rd("neg_ch1", IDX_NEG_OV_LATCH, 8'h80);
      @(posedge clk_sys);
      ch2_ov <= 1'b1;
      @(posedge clk_sys);
      ch2_ov <= 1'b0;
      settle();
      chk_rd("neg_both", IDX_NEG_OV_LATCH, 8'hc0);
      chk_rd("ch2_latch", IDX_CH2_LATCH, 8'h00);
      chk_rd("neg_keep1", IDX_NEG_OV_LATCH, 8'h80);
      chk_rd("ch1_latch", IDX_CH1_LATCH, 8'h00);
      chk_rd("neg_clear", IDX_NEG_OV_LATCH, 8'h00);
      // High current: lowest limits, load taken back into range before reading
      wr(IDX_LOW_LIMIT, 8'd57);
      wr(IDX_HIGH_LIMIT, 8'd58);
      load_ua <= th_ua(58) + 17'd60;
      settle();
      `CHK("alert_high", 1'b1, bias_fault_alert)
      load_ua <= th_ua(58) / 17'd2;
      settle();
      chk_rd("bias_high", IDX_BIAS_LATCH, 8'h80);
      chk_rd("bias_high_clr", IDX_BIAS_LATCH, 8'h00);
      load_ua <= th_ua(58); // Equal to the limit is no fault
      settle();
      chk_rd("bias_high_eq", IDX_BIAS_LATCH, 8'h00);
      // Low current just under its limit, then exactly on it
      wr(IDX_HIGH_LIMIT, 8'd242);
      wr(IDX_LOW_LIMIT, 8'd59);
      load_ua <= th_ua(59) - 17'd1;
      settle();
      load_ua <= th_ua(59);
      settle();
      chk_rd("bias_low", IDX_BIAS_LATCH, 8'h40);
      chk_rd("bias_low_clr", IDX_BIAS_LATCH, 8'h00);
      @(posedge clk_sys);
      bias_ov <= 1'b1;
      @(posedge clk_sys);
      bias_ov <= 1'b0;
      settle();
      chk_rd("bias_ov", IDX_BIAS_LATCH, 8'h20);
      chk_rd("bias_ov_clr", IDX_BIAS_LATCH, 8'h00);
      // Masked high-current fault latches but stays off the alert
      wr(IDX_MASK_THREE, 8'h20);
      wr(IDX_LOW_LIMIT, 8'd57);
      wr(IDX_HIGH_LIMIT, 8'd58);
      settle();
      `CHK("alert_masked", 1'b0, bias_fault_alert)
      load_ua <= th_ua(58) / 17'd2;
      settle();
      chk_rd("bias_masked", IDX_BIAS_LATCH, 8'h80);
      wr(IDX_MASK_THREE, 8'h00);
      // Second reset mid-run brings the limits back
      load_ua <= 17'd20000;
      do_reset();
      chk_rd("high_rst2", IDX_HIGH_LIMIT, 8'hba);
      chk_rd("low_rst2", IDX_LOW_LIMIT, 8'h4b);
      chk_rd("bias_rst2", IDX_BIAS_LATCH, 8'h00);
      @(negedge clk_sys);
      `CHK("alert_rst2", 1'b0, bias_fault_alert)
      summarize();
   end

endmodule // tb_top
